// file: common/slsr_cfg.svh
// Functional notes
// - Lock bits protect only when select is 1
// - Select 0: protect from complement, granularity, field
// - Lock bits volatile, all 1 after reset
// - Unlock accepted only with write latch set
// - Lock byte out on falling edges, MSB first
// - Byte LSB 1 locked, 0 unlocked
// - 7Eh with no address sets all locks
// - 98h with no address clears all locks
// - Global commands need write latch set
// - Instruction bits sampled on rising clock edges
// - Reset needs 66h immediately followed by 99h
// - Other instruction after 66h cancels reset enable
// - Reset restores power-on volatile state
// - Reset takes 30us before normal operation
// - Instructions ignored during reset recovery
`ifndef SLSR_CFG_SVH
`define SLSR_CFG_SVH

// Instruction codes
`define SLSR_OP_WREN      8'h06
`define SLSR_OP_WRDI      8'h04
`define SLSR_OP_LOCK      8'h36
`define SLSR_OP_UNLOCK    8'h39
`define SLSR_OP_RDLOCK    8'h3D
`define SLSR_OP_GLOCK     8'h7E
`define SLSR_OP_GUNLOCK   8'h98
`define SLSR_OP_RSTEN     8'h66
`define SLSR_OP_RST       8'h99

// Frame bit counts
`define SLSR_OPC_BITS     6'h08
`define SLSR_ADDR_BITS    6'h20
`define SLSR_BIT_MAX      6'h3F
`define SLSR_OUT_LSB_POS  3'h7

// Lock array geometry: one lock per 64 KB block
`define SLSR_NUM_LOCKS    32
`define SLSR_IDX_W        5
`define SLSR_IDX_LSB      16
`define SLSR_LOCK_RESET   1'h1

// Block-protect decode sizes
`define SLSR_ARRAY_BYTES  23'h200000
`define SLSR_BLOCK_BYTES  23'h010000
`define SLSR_SECT_BYTES   23'h001000
`define SLSR_SECT_MAX_CODE 3'h5
`define SLSR_SECT_CAP     23'h008000

// Reset recovery time
`define SLSR_T_RST_US     30
`define SLSR_CLK_MHZ      50
`define SLSR_RST_CYCLES   (`SLSR_T_RST_US * `SLSR_CLK_MHZ)
`define SLSR_RCNT_W       11

`endif

// file: common/slsr_pkg.sv
package slsr_pkg;
	typedef enum logic [1:0] {
		SLSR_IDLE,
		SLSR_SHIFT,
		SLSR_OUT,
		SLSR_SKIP
	} slsr_state_t;
endpackage : slsr_pkg

// file: rtl/slsr_lock_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "slsr_cfg.svh"
module slsr_lock_mem (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   wr_en,
	input  wire logic [`SLSR_IDX_W-1:0] wr_idx,
	input  wire logic                   wr_val,
	input  wire logic                   set_all,
	input  wire logic                   clr_all,
	input  wire logic [`SLSR_IDX_W-1:0] rd_idx_a,
	input  wire logic [`SLSR_IDX_W-1:0] rd_idx_b,
	output logic                        rd_a,
	output logic                        rd_b
);
	logic [`SLSR_NUM_LOCKS-1:0] lock;
	logic [`SLSR_NUM_LOCKS-1:0] next_lock;

	// Per-entry update; global commands beat single writes
	genvar i;
	generate
		for (i = 0; i < `SLSR_NUM_LOCKS; i = i + 1) begin : g_ent
			always_comb begin
				if (set_all) begin
					next_lock[i] = 1'h1;
				end else if (clr_all) begin
					next_lock[i] = 1'h0;
				end else if (wr_en && wr_idx == `SLSR_IDX_W'(i)) begin
					next_lock[i] = wr_val;
				end else begin
					next_lock[i] = lock[i];
				end
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					lock[i] <= `SLSR_LOCK_RESET;
				end else begin
					lock[i] <= next_lock[i];
				end
			end
		end
	endgenerate

	// Registered read ports
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_a <= `SLSR_LOCK_RESET;
			rd_b <= `SLSR_LOCK_RESET;
		end else begin
			rd_a <= lock[rd_idx_a];
			rd_b <= lock[rd_idx_b];
		end
	end
endmodule : slsr_lock_mem
`default_nettype wire

// file: rtl/slsr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "slsr_cfg.svh"
module slsr_top
	import slsr_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        SPI_CS_N,
	input  wire logic        SPI_SCK,
	input  wire logic        SERIAL_INPUT,
	input  wire logic        PER_SECTOR_PROTECT_SELECT,
	input  wire logic        PROTECT_COMPLEMENT,
	input  wire logic        SECTOR_GRANULARITY_SELECT,
	input  wire logic        TOP_BOTTOM_SELECT,
	input  wire logic [2:0]  BLOCK_PROTECT_FIELD,
	input  wire logic [23:0] CHECK_ADDR,
	output logic             SERIAL_OUTPUT,
	output logic             SERIAL_OUTPUT_OE_N,
	output logic             WRITE_LATCH_FLAG,
	output logic             WRITE_PROTECTED,
	output logic             RESET_RECOVERY,
	output logic             VOLATILE_CLEAR
);
	// Pin synchronisers; stage 1 feeds stage 2 only
	logic [2:0] cs_sync;
	logic [2:0] sck_sync;
	logic [1:0] si_sync;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cs_sync  <= 3'h7;
			sck_sync <= 3'h0;
			si_sync  <= 2'h0;
		end else begin
			cs_sync  <= {cs_sync[1:0], SPI_CS_N};
			sck_sync <= {sck_sync[1:0], SPI_SCK};
			si_sync  <= {si_sync[0], SERIAL_INPUT};
		end
	end

	// Edges judged from stages 2 and 3 only
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	logic cs_low;
	logic si_bit;
	assign sck_rise = sck_sync[1] & ~sck_sync[2];
	assign sck_fall = ~sck_sync[1] & sck_sync[2];
	assign cs_fall  = ~cs_sync[1] & cs_sync[2];
	assign cs_rise  = cs_sync[1] & ~cs_sync[2];
	assign cs_low   = ~cs_sync[1];
	assign si_bit   = si_sync[1];

	// Frame and command state
	slsr_state_t             state;
	slsr_state_t             next_state;
	logic [5:0]              bit_cnt;
	logic [5:0]              next_bit_cnt;
	logic [7:0]              opcode;
	logic [7:0]              next_opcode;
	logic [23:0]             addr_sh;
	logic [23:0]             next_addr_sh;
	logic [2:0]              out_cnt;
	logic [2:0]              next_out_cnt;
	logic                    so;
	logic                    next_so;
	logic                    so_oe_n;
	logic                    next_so_oe_n;
	logic                    wlatch;
	logic                    next_wlatch;
	logic                    rst_en;
	logic                    next_rst_en;
	logic [`SLSR_RCNT_W-1:0] rec_cnt;
	logic [`SLSR_RCNT_W-1:0] next_rec_cnt;
	logic                    recovering;
	logic                    next_recovering;
	logic                    vclr;
	logic                    next_vclr;

	// Lock memory controls
	logic                  mem_wr;
	logic                  mem_val;
	logic                  mem_set_all;
	logic                  mem_clr_all;
	logic                  lock_rd;
	logic                  lock_chk;
	logic [`SLSR_IDX_W-1:0] cmd_idx;
	logic [`SLSR_IDX_W-1:0] chk_idx;
	assign cmd_idx = addr_sh[`SLSR_IDX_LSB +: `SLSR_IDX_W];
	assign chk_idx = CHECK_ADDR[`SLSR_IDX_LSB +: `SLSR_IDX_W];

	slsr_lock_mem u_mem (
		.clk      (CLK),
		.reset_n  (RESET_N),
		.wr_en    (mem_wr),
		.wr_idx   (cmd_idx),
		.wr_val   (mem_val),
		.set_all  (mem_set_all),
		.clr_all  (mem_clr_all),
		.rd_idx_a (cmd_idx),
		.rd_idx_b (chk_idx),
		.rd_a     (lock_rd),
		.rd_b     (lock_chk)
	);

	// Command decode, execution at chip-select release
	always_comb begin
		next_state      = state;
		next_bit_cnt    = bit_cnt;
		next_opcode     = opcode;
		next_addr_sh    = addr_sh;
		next_out_cnt    = out_cnt;
		next_so         = so;
		next_so_oe_n    = so_oe_n;
		next_wlatch     = wlatch;
		next_rst_en     = rst_en;
		next_rec_cnt    = rec_cnt;
		next_recovering = recovering;
		next_vclr       = 1'h0;
		mem_wr          = 1'h0;
		mem_val         = 1'h0;
		mem_set_all     = 1'h0;
		mem_clr_all     = 1'h0;
		if (recovering) begin
			// Whole frames begun in recovery stay ignored
			if (rec_cnt == `SLSR_RCNT_W'(1)) begin
				next_recovering = 1'h0;
			end
			next_rec_cnt = rec_cnt - `SLSR_RCNT_W'(1);
			if (cs_fall) begin
				next_state = SLSR_SKIP;
			end
		end
		if (cs_rise) begin
			next_state   = SLSR_IDLE;
			next_so      = 1'h0;
			next_so_oe_n = 1'h1;
			// Readback frames end in the output state and must cancel too
			if ((state == SLSR_SHIFT || state == SLSR_OUT) && !recovering) begin
				if (bit_cnt >= `SLSR_OPC_BITS) begin
					next_rst_en = 1'h0;
				end
				if (bit_cnt == `SLSR_OPC_BITS) begin
					case (opcode)
						`SLSR_OP_WREN: next_wlatch = 1'h1;
						`SLSR_OP_WRDI: next_wlatch = 1'h0;
						`SLSR_OP_GLOCK: mem_set_all = wlatch;
						`SLSR_OP_GUNLOCK: mem_clr_all = wlatch;
						`SLSR_OP_RSTEN: next_rst_en = 1'h1;
						`SLSR_OP_RST: begin
							if (rst_en) begin
								// Abort: locks to 1, latch off, others told
								mem_set_all     = 1'h1;
								next_wlatch     = 1'h0;
								next_vclr       = 1'h1;
								next_recovering = 1'h1;
								next_rec_cnt    = `SLSR_RCNT_W'(`SLSR_RST_CYCLES);
							end
						end
						default: next_rst_en = 1'h0;
					endcase
				end else if (bit_cnt == `SLSR_ADDR_BITS) begin
					if (opcode == `SLSR_OP_UNLOCK) begin
						mem_wr  = wlatch;
						mem_val = 1'h0;
					end else if (opcode == `SLSR_OP_LOCK) begin
						mem_wr  = wlatch;
						mem_val = 1'h1;
					end
				end
			end
		end else if (cs_fall && !recovering) begin
			next_state   = SLSR_SHIFT;
			next_bit_cnt = 6'h00;
		end else if (cs_low) begin
			case (state)
				SLSR_SHIFT: begin
					if (sck_rise) begin
						next_addr_sh = {addr_sh[22:0], si_bit};
						if (bit_cnt != `SLSR_BIT_MAX) begin
							next_bit_cnt = bit_cnt + 6'h01;
						end
						if (bit_cnt == `SLSR_OPC_BITS - 6'h01) begin
							next_opcode = {addr_sh[6:0], si_bit};
						end
						if (bit_cnt == `SLSR_ADDR_BITS - 6'h01
							&& opcode == `SLSR_OP_RDLOCK) begin
							next_state   = SLSR_OUT;
							next_out_cnt = 3'h0;
						end
					end
				end
				SLSR_OUT: begin
					// Seven zeros, then the lock state; repeats per byte
					if (sck_fall) begin
						next_so_oe_n = 1'h0;
						next_so      = (out_cnt == `SLSR_OUT_LSB_POS) ? lock_rd : 1'h0;
						next_out_cnt = out_cnt + 3'h1;
					end
				end
				SLSR_IDLE: next_state = (recovering && cs_fall) ? SLSR_SKIP : SLSR_IDLE;
				SLSR_SKIP: next_state = SLSR_SKIP;
				default: next_state = SLSR_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state      <= SLSR_IDLE;
			bit_cnt    <= 6'h00;
			opcode     <= 8'h00;
			addr_sh    <= 24'h000000;
			out_cnt    <= 3'h0;
			so         <= 1'h0;
			so_oe_n    <= 1'h1;
			wlatch     <= 1'h0;
			rst_en     <= 1'h0;
			rec_cnt    <= `SLSR_RCNT_W'(0);
			recovering <= 1'h0;
			vclr       <= 1'h0;
		end else begin
			state      <= next_state;
			bit_cnt    <= next_bit_cnt;
			opcode     <= next_opcode;
			addr_sh    <= next_addr_sh;
			out_cnt    <= next_out_cnt;
			so         <= next_so;
			so_oe_n    <= next_so_oe_n;
			wlatch     <= next_wlatch;
			rst_en     <= next_rst_en;
			rec_cnt    <= next_rec_cnt;
			recovering <= next_recovering;
			vclr       <= next_vclr;
		end
	end

	// Range protection; sector sizes capped, larger fields alias the cap
	logic [22:0] chk_a;
	logic [22:0] prot_size;
	logic        range_hit;
	logic        next_wp;
	always_comb begin
		chk_a = {2'h0, CHECK_ADDR[20:0]};
		if (SECTOR_GRANULARITY_SELECT) begin
			if (BLOCK_PROTECT_FIELD >= `SLSR_SECT_MAX_CODE) begin
				prot_size = `SLSR_SECT_CAP;
			end else begin
				prot_size = `SLSR_SECT_BYTES << (BLOCK_PROTECT_FIELD - 3'h1);
			end
		end else begin
			prot_size = `SLSR_BLOCK_BYTES << (BLOCK_PROTECT_FIELD - 3'h1);
		end
		if (BLOCK_PROTECT_FIELD == 3'h0) begin
			range_hit = 1'h0;
		end else if (TOP_BOTTOM_SELECT) begin
			range_hit = chk_a < prot_size;
		end else begin
			range_hit = (chk_a + prot_size) >= `SLSR_ARRAY_BYTES;
		end
		if (PER_SECTOR_PROTECT_SELECT) begin
			next_wp = lock_chk;
		end else begin
			next_wp = range_hit ^ PROTECT_COMPLEMENT;
		end
	end

	logic wp;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wp <= 1'h1;
		end else begin
			wp <= next_wp;
		end
	end

	// Every output straight from a flop
	assign SERIAL_OUTPUT      = so;
	assign SERIAL_OUTPUT_OE_N = so_oe_n;
	assign WRITE_LATCH_FLAG   = wlatch;
	assign WRITE_PROTECTED    = wp;
	assign RESET_RECOVERY     = recovering;
	assign VOLATILE_CLEAR     = vclr;
endmodule : slsr_top
`default_nettype wire

// file: tb/slsr_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller, mode 0, clock stands low between frames
module slsr_host (
	input  wire logic clk,
	input  wire logic so,
	output logic      cs_n,
	output logic      sck,
	output logic      si
);
	initial begin
		cs_n = 1'h1;
		sck = 1'h0;
		si = 1'h0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask : w
	// Halves of 5 cycles beat the 3-flop input lag
	task automatic frame(input logic [31:0] v, input int n, input int m, output logic [7:0] rd);
		rd = 8'h00;
		w(1);
		cs_n <= 1'h0;
		for (int i = n - 1; i >= 0; i--) begin
			si <= v[i];
			w(5);
			sck <= 1'h1;
			w(5);
			sck <= 1'h0;
		end
		si <= ~si; // Last bit inverted, no stale level
		for (int i = m - 1; i >= 0; i--) begin
			w(5);
			sck <= 1'h1;
			rd[i] = so;
			w(5);
			sck <= 1'h0;
		end
		w(5);
		cs_n <= 1'h1;
		w(6);
	endtask : frame
endmodule : slsr_host
`default_nettype wire

// file: tb/slsr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module slsr_top_bench;
	logic        clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        sel = 1'h0;
	logic        cmpl = 1'h0;
	logic        bottom_sel = 1'h0;
	logic        gran = 1'h0;
	logic [2:0]  prot_code = 3'h0;
	logic [23:0] chk_addr = 24'h000000;
	logic [7:0]  rd;
	wire logic   cs_n, sck, si, so, so_oe_n, wlf, wp, rec, vclr;
	wire logic   so_pin;
	int          err_total = 0;
	int          tests_run = 0;
	int          vclr_seen = 0;
	always #10 clk = ~clk;
	// Clear pulses counted mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (vclr === 1'h1) begin
			vclr_seen++;
		end
	end
	// Line pulled up while released
	assign so_pin = so_oe_n ? 1'h1 : so;
	slsr_top slsr_top_i (.CLK(clk), .RESET_N(reset_n), .SPI_CS_N(cs_n), .SPI_SCK(sck),
		.SERIAL_INPUT(si), .PER_SECTOR_PROTECT_SELECT(sel), .PROTECT_COMPLEMENT(cmpl),
		.SECTOR_GRANULARITY_SELECT(gran), .TOP_BOTTOM_SELECT(bottom_sel),
		.BLOCK_PROTECT_FIELD(prot_code), .CHECK_ADDR(chk_addr), .SERIAL_OUTPUT(so),
		.SERIAL_OUTPUT_OE_N(so_oe_n), .WRITE_LATCH_FLAG(wlf), .WRITE_PROTECTED(wp),
		.RESET_RECOVERY(rec), .VOLATILE_CLEAR(vclr));
	slsr_host slsr_host_i (.clk(clk), .so(so_pin), .cs_n(cs_n), .sck(sck), .si(si));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic flag(input string s, input logic e, input logic g);
		chk(s, {7'h00, e}, {7'h00, g});
	endtask : flag
	task automatic op(input logic [7:0] c);
		slsr_host_i.frame({24'h000000, c}, 8, 0, rd);
	endtask : op
	task automatic adr(input logic [7:0] c, input logic [4:0] b);
		slsr_host_i.frame({c, 3'h0, b, 16'h0000}, 32, 0, rd);
	endtask : adr
	task automatic rb(input logic [4:0] b, input logic [7:0] e);
		slsr_host_i.frame({8'h3D, 3'h0, b, 16'h0000}, 32, 8, rd);
		chk("lock byte", e, rd);
	endtask : rb
	// Settle protect inputs, then read the verdict
	task automatic prot(input logic s, input logic [2:0] b, input logic c, input logic t,
		input logic [23:0] a, input logic e);
		sel <= s;
		prot_code <= b;
		cmpl <= c;
		bottom_sel <= t;
		chk_addr <= a;
		slsr_host_i.w(6);
		flag("protect", e, wp);
	endtask : prot
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		slsr_host_i.w(4);
		rb(5'h03, 8'h01);
		flag("latch", 1'h0, wlf);
		adr(8'h39, 5'h03);
		rb(5'h03, 8'h01);
		op(8'h06);
		flag("latch", 1'h1, wlf);
		adr(8'h39, 5'h03);
		rb(5'h03, 8'h00);
		rb(5'h04, 8'h01);
		$display("test unlock done");
		prot(1'h1, 3'h0, 1'h0, 1'h0, 24'h030000, 1'h0);
		prot(1'h1, 3'h0, 1'h0, 1'h0, 24'h040000, 1'h1);
		prot(1'h0, 3'h1, 1'h0, 1'h0, 24'h1F0000, 1'h1);
		prot(1'h0, 3'h1, 1'h0, 1'h1, 24'h1F0000, 1'h0);
		prot(1'h0, 3'h1, 1'h1, 1'h1, 24'h1F0000, 1'h1);
		// Sector granularity: smallest bottom range is one 4 KB unit
		gran <= 1'h1;
		prot(1'h0, 3'h1, 1'h0, 1'h1, 24'h000FFF, 1'h1);
		prot(1'h0, 3'h1, 1'h0, 1'h1, 24'h001000, 1'h0);
		gran <= 1'h0;
		prot(1'h0, 3'h0, 1'h0, 1'h0, 24'h040000, 1'h0);
		$display("test protect done");
		op(8'h98);
		rb(5'h04, 8'h00);
		op(8'h04);
		op(8'h7E);
		rb(5'h1F, 8'h00);
		op(8'h06);
		op(8'h7E);
		rb(5'h1F, 8'h01);
		$display("test global done");
		op(8'h98);
		op(8'h66);
		op(8'h06);
		op(8'h99);
		flag("recovery", 1'h0, rec);
		rb(5'h02, 8'h00);
		// A readback between the two steps must cancel as well
		op(8'h66);
		rb(5'h02, 8'h00);
		op(8'h99);
		flag("recovery", 1'h0, rec);
		// No busy or suspend state pending here
		op(8'h66);
		op(8'h99);
		flag("recovery", 1'h1, rec);
		flag("latch", 1'h0, wlf);
		chk("clear pulses", 8'h01, vclr_seen[7:0]);
		op(8'h06);
		flag("latch", 1'h0, wlf);
		rb(5'h02, 8'hFF);
		for (int i = 0; i < 2000 && rec === 1'h1; i++) @(posedge clk);
		flag("recovery", 1'h0, rec);
		rb(5'h02, 8'h01);
		$display("test reset done");
		close_out();
	end
endmodule : slsr_top_bench
`default_nettype wire

// file: tb/slsr_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "slsr_cfg.svh"
module slsr_top_chk (
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic       SPI_CS_N,
	input  wire logic       PER_SECTOR_PROTECT_SELECT,
	input  wire logic       PROTECT_COMPLEMENT,
	input  wire logic [2:0] BLOCK_PROTECT_FIELD,
	input  wire logic       SERIAL_OUTPUT,
	input  wire logic       SERIAL_OUTPUT_OE_N,
	input  wire logic       WRITE_LATCH_FLAG,
	input  wire logic       WRITE_PROTECTED,
	input  wire logic       RESET_RECOVERY,
	input  wire logic       VOLATILE_CLEAR
);
	logic [10:0] rec_cnt;
	logic [10:0] next_rec_cnt;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// Length of the running recovery, cleared when it ends
	always_comb begin
		next_rec_cnt = RESET_RECOVERY ? rec_cnt + 11'h001 : 11'h000;
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rec_cnt <= 11'h000;
		end else begin
			rec_cnt <= next_rec_cnt;
		end
	end
	// Long deselect window clears any sync-flop lag
	oe_idle_a: assert property (SPI_CS_N [*8] |-> SERIAL_OUTPUT_OE_N)
		else $error("output driven while deselected");
	so_quiet_a: assert property (SERIAL_OUTPUT_OE_N |-> !SERIAL_OUTPUT)
		else $error("output high while released");
	rec_len_a: assert property ($fell(RESET_RECOVERY) |-> rec_cnt == `SLSR_RST_CYCLES)
		else $error("recovery length wrong");
	rec_wlf_a: assert property ($rose(RESET_RECOVERY) |-> !WRITE_LATCH_FLAG)
		else $error("latch not cleared by reset");
	vclr_pulse_a: assert property (VOLATILE_CLEAR |=> !VOLATILE_CLEAR)
		else $error("clear pulse too long");
	vclr_rec_a: assert property (VOLATILE_CLEAR |-> ##[0:1] RESET_RECOVERY)
		else $error("clear pulse without recovery");
	rec_ign_a: assert property (RESET_RECOVERY |-> !WRITE_LATCH_FLAG)
		else $error("command taken during recovery");
	wlf_hold_a: assert property ((!SPI_CS_N) [*6] |-> $stable(WRITE_LATCH_FLAG))
		else $error("latch moved inside a frame");
	range_off_a: assert property ((!PER_SECTOR_PROTECT_SELECT && !PROTECT_COMPLEMENT
		&& BLOCK_PROTECT_FIELD == 3'h0) [*4] |-> !WRITE_PROTECTED)
		else $error("protected with empty range");
	cover property ($rose(RESET_RECOVERY));
	cover property (!SERIAL_OUTPUT_OE_N && SERIAL_OUTPUT);
	cover property ($fell(WRITE_LATCH_FLAG));
endmodule : slsr_top_chk
bind slsr_top slsr_top_chk slsr_top_chk_i (.CLK(CLK), .RESET_N(RESET_N), .SPI_CS_N(SPI_CS_N),
	.PER_SECTOR_PROTECT_SELECT(PER_SECTOR_PROTECT_SELECT),
	.PROTECT_COMPLEMENT(PROTECT_COMPLEMENT), .BLOCK_PROTECT_FIELD(BLOCK_PROTECT_FIELD),
	.SERIAL_OUTPUT(SERIAL_OUTPUT), .SERIAL_OUTPUT_OE_N(SERIAL_OUTPUT_OE_N),
	.WRITE_LATCH_FLAG(WRITE_LATCH_FLAG), .WRITE_PROTECTED(WRITE_PROTECTED),
	.RESET_RECOVERY(RESET_RECOVERY), .VOLATILE_CLEAR(VOLATILE_CLEAR));
`default_nettype wire
